/* File: tcp_pkg.sv */
package tcp_pkg;

    // Timer modes, four-bit code with mode extension on top
    typedef enum logic [3:0] {
        TCP_ONE_SHOT   = 4'h0,
        TCP_CONTINUOUS = 4'h1,
        TCP_COUNTER    = 4'h2,
        TCP_PWM_SINGLE = 4'h3,
        TCP_CAPTURE    = 4'h4,
        TCP_COMPARE    = 4'h5,
        TCP_GATED      = 4'h6,
        TCP_CAP_CMP    = 4'h7,
        TCP_PWM_DUAL   = 4'h8,
        TCP_CAP_RESTART= 4'h9,
        TCP_CMP_COUNTER= 4'hA
    } tcp_mode_e;

    // Interrupt source select codes
    localparam logic [1:0] TCP_IRQ_BOTH    = 2'h0;
    localparam logic [1:0] TCP_IRQ_CAPTURE = 2'h2;
    localparam logic [1:0] TCP_IRQ_RELOAD  = 2'h3;

    // Values after reset and restart
    localparam logic [15:0] TCP_COUNT_START = 16'h0001;
    localparam logic [15:0] TCP_COUNT_RST   = 16'h0000;
    localparam logic [15:0] TCP_RELOAD_RST  = 16'hFFFF;
    localparam logic [7:0]  TCP_PRESC_RST   = 8'h00;

    // Software configuration carried as one group
    typedef struct packed {
        logic       enable;           // Timer running
        tcp_mode_e  mode;             // Mode incl. extension bit
        logic       output_polarity_bit;
        logic [2:0] clock_divide_power;
        logic [2:0] dead_time_delay;
        logic [1:0] irq_source_select;
    } tcp_cfg_s;

endpackage

/* File: tcp_sync.sv */
`timescale 1ns/10ps
// Two-stage synchroniser for the timer input pin
module tcp_sync
    import tcp_pkg::*;
(
    input  wire logic clk_i,      // System clock
    input  wire logic reset_n_i,  // Async reset, active low
    input  wire logic d_i,        // Asynchronous level
    output logic      q_o         // Synchronised level
);
    logic [1:0] sync_reg;         // Stage one read only by stage two

    // Plain shift; nothing taps the first stage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_reg <= 2'h0;
        end else begin
            sync_reg <= {sync_reg[0], d_i};
        end
    end

    assign q_o = sync_reg[1];
endmodule

/* File: tcp_prescaler.sv */
`timescale 1ns/10ps
// Power-of-two prescaler giving one tick per divided period
module tcp_prescaler
    import tcp_pkg::*;
#(
    parameter int W = 8           // Divider width, covers 2**7
)(
    input  wire logic       clk_i,     // System clock
    input  wire logic       reset_n_i, // Async reset, active low
    input  wire logic       run_i,     // Timer enabled
    input  wire logic [2:0] power_i,   // Divide exponent
    output logic            tick_o     // One-cycle count enable
);
    logic [W-1:0] cnt_reg;        // Free divider
    logic [W-1:0] mask;           // Low bits that must be all ones

    assign mask   = W'((16'h0001 << power_i) - 16'h0001);
    assign tick_o = run_i && ((cnt_reg & mask) == mask);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= W'(TCP_PRESC_RST);
        end else if (!run_i) begin
            cnt_reg <= W'(TCP_PRESC_RST);
        end else begin
            cnt_reg <= cnt_reg + W'(1);
        end
    end
endmodule

/* File: tcp_timer.sv */
`timescale 1ns/10ps
// 16-bit timer: capture restart, compare, capture/compare,
// PWM dual output and comparator counter
module tcp_timer
    import tcp_pkg::*;
(
    input  wire logic        clk_i,          // System clock
    input  wire logic        reset_n_i,      // Async reset, active low
    input  wire tcp_cfg_s    cfg_i,          // Control fields
    input  wire logic        count_wr_i,     // Load running count
    input  wire logic [15:0] count_wdata_i,  // Count write data
    input  wire logic [15:0] reload_i,       // Reload / compare value
    input  wire logic        pwm_wr_i,       // Load PWM register
    input  wire logic [15:0] pwm_wdata_i,    // PWM write data
    input  wire logic        pin_alt_en_i,   // Output alt function on
    input  wire logic        timer_in_i,     // Timer input pin, async
    output logic [15:0]      count_o,        // Running count
    output logic [15:0]      pwm_o,          // PWM / capture register
    output logic             capture_cause_flag_o, // Last restart by capture, irq or not (capture restart, cap/compare modes)
    output logic             irq_o,          // Interrupt pulse
    output logic             timer_out_pin_o,     // Output pin level
    output logic             timer_out_pin_oe_o,  // Output pin enable
    output logic             timer_out_comp_o,    // Complement level
    output logic             timer_out_comp_oe_o  // Complement enable
);
    // State of the block, apart from synchroniser and prescaler, in one struct
    typedef struct packed {
        logic [15:0] count;       // Running count
        logic [15:0] pwm;         // PWM value, capture result
        logic        cap_flag;    // Capture-cause flag
        logic        irq;         // Interrupt pulse
        logic        started;     // Cap/compare first edge seen
        logic        out_lvl;     // Undelayed output state
        logic        pol_run;     // Polarity latched at enable
        logic [2:0]  dead_cnt;    // Dead time remaining
        logic        out;         // Pin level
        logic        comp;        // Complement level
        logic        comp_oe;     // Complement enable
        logic        in_prev;     // Input level last cycle
        logic        en_prev;     // Enable last cycle
        logic        pin_oe;      // Registered alt-function enable
    } tcp_state_s;

    tcp_state_s st_reg;           // Registered state
    tcp_state_s st_next;          // Next state
    logic       in_sync;          // Synchronised input
    logic       tick;             // Prescaled count enable
    logic       edge_det;         // Selected input edge
    logic       hit_reload;       // Count equals reload
    logic       hit_pwm;          // Count equals PWM value
    logic       pol;              // Polarity in effect

    // Input pin crosses into clock domain first
    tcp_sync u_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .d_i       (timer_in_i),
        .q_o       (in_sync)
    );

    tcp_prescaler #(.W(8)) u_presc (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .run_i     (cfg_i.enable),
        .power_i   (cfg_i.clock_divide_power),
        .tick_o    (tick)
    );

    // Irq gating by source select
    function automatic logic irq_allow(input logic [1:0] sel,
                                       input logic       is_cap);
        // Both by default, else one kind only
        unique case (sel)
            TCP_IRQ_CAPTURE: irq_allow = is_cap;
            TCP_IRQ_RELOAD:  irq_allow = !is_cap;
            default:         irq_allow = 1'b1;
        endcase
    endfunction

    // Running logic uses polarity latched at enable
    // First enabled cycle has no latched copy yet, so use the field
    assign pol = (cfg_i.enable && st_reg.en_prev) ? st_reg.pol_run
                                                  : cfg_i.output_polarity_bit;

    // Rising for polarity 0, falling for 1
    assign edge_det = pol ? (st_reg.in_prev && !in_sync)
                          : (!st_reg.in_prev && in_sync);
    assign hit_reload = (st_reg.count == reload_i);
    assign hit_pwm    = (st_reg.count == st_reg.pwm);

    // Next-state logic
    always_comb begin
        st_next         = st_reg;
        st_next.irq     = 1'b0;
        st_next.in_prev = in_sync;
        st_next.en_prev = cfg_i.enable;
        // Complement driven in dual mode, even at rest
        st_next.comp_oe = (cfg_i.mode == TCP_PWM_DUAL);
        st_next.pin_oe  = pin_alt_en_i;
        if (cfg_i.enable && !st_reg.en_prev) begin
            st_next.pol_run = cfg_i.output_polarity_bit;
        end
        if (count_wr_i) begin
            st_next.count = count_wdata_i;
        end
        if (pwm_wr_i) begin
            st_next.pwm = pwm_wdata_i;
        end
        if (!cfg_i.enable) begin
            // Disabled: output pin rests at polarity level, complement at its inverse
            st_next.started  = 1'b0;
            st_next.dead_cnt = 3'h0;
            st_next.out_lvl  = cfg_i.output_polarity_bit;
            st_next.out      = cfg_i.output_polarity_bit;
            st_next.comp     = !cfg_i.output_polarity_bit;
        end else begin
            unique case (cfg_i.mode)
                TCP_CAP_RESTART: begin
                    if (edge_det) begin
                        st_next.pwm      = st_reg.count;
                        st_next.count    = TCP_COUNT_START;
                        st_next.cap_flag = 1'b1;
                        st_next.irq = irq_allow(cfg_i.irq_source_select,
                                                1'b1);
                    end else if (tick && hit_reload) begin
                        st_next.count    = TCP_COUNT_START;
                        st_next.cap_flag = 1'b0;
                        st_next.irq = irq_allow(cfg_i.irq_source_select,
                                                1'b0);
                    end else if (tick) begin
                        st_next.count = st_reg.count + 16'h0001;
                    end
                end
                TCP_COMPARE: begin
                    if (tick) begin
                        st_next.count = st_reg.count + 16'h0001;
                        st_next.irq   = hit_reload;
                    end
                end
                TCP_CAP_CMP: begin
                    if (!st_reg.started) begin
                        st_next.started = edge_det;
                    end else if (edge_det) begin
                        st_next.pwm      = st_reg.count;
                        st_next.count    = TCP_COUNT_START;
                        st_next.cap_flag = 1'b1;
                        st_next.irq = irq_allow(cfg_i.irq_source_select,
                                                1'b1);
                    end else if (tick && hit_reload) begin
                        st_next.count    = TCP_COUNT_START;
                        st_next.cap_flag = 1'b0;
                        st_next.irq = irq_allow(cfg_i.irq_source_select,
                                                1'b0);
                    end else if (tick) begin
                        st_next.count = st_reg.count + 16'h0001;
                    end
                end
                TCP_PWM_DUAL: begin
                    if (tick && hit_reload) begin
                        st_next.count   = TCP_COUNT_START;
                        st_next.irq     = 1'b1;
                        st_next.out_lvl = pol;
                        st_next.dead_cnt = cfg_i.dead_time_delay;
                    end else if (tick) begin
                        st_next.count = st_reg.count + 16'h0001;
                        if (hit_pwm) begin
                            st_next.out_lvl  = !pol;
                            st_next.dead_cnt = cfg_i.dead_time_delay;
                        end
                    end
                    // Inactive edge at once, active after delay
                    if (st_next.out_lvl != st_reg.out_lvl) begin
                        if (st_next.out_lvl == !pol) begin
                            // Match: complement drops now, output waits
                            st_next.comp = pol;
                            st_next.out  = (cfg_i.dead_time_delay == 3'h0)
                                         ? !pol : pol;
                        end else begin
                            // Reload: output drops now, complement waits
                            st_next.out  = pol;
                            st_next.comp = (cfg_i.dead_time_delay == 3'h0)
                                         ? !pol : pol;
                        end
                    end else if (st_reg.dead_cnt != 3'h0) begin
                        st_next.dead_cnt = st_reg.dead_cnt - 3'h1;
                        if (st_reg.dead_cnt == 3'h1) begin
                            st_next.out  = st_reg.out_lvl;
                            st_next.comp = !st_reg.out_lvl;
                        end
                    end
                end
                TCP_CMP_COUNTER: begin
                    if (tick && hit_reload) begin
                        st_next.count = TCP_COUNT_START;
                        st_next.irq   = 1'b1;
                        st_next.out   = !st_reg.out;
                    end else if (tick) begin
                        st_next.count = st_reg.count + 16'h0001;
                    end
                end
                default: begin
                    // Other modes: free count with reload
                    if (tick && hit_reload) begin
                        st_next.count = TCP_COUNT_START;
                        st_next.irq   = 1'b1;
                        st_next.out   = !st_reg.out;
                    end else if (tick) begin
                        st_next.count = st_reg.count + 16'h0001;
                    end
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg          <= '0;
            st_reg.count    <= TCP_COUNT_RST;
            st_reg.comp     <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flip-flops
    assign count_o              = st_reg.count;
    assign pwm_o                = st_reg.pwm;
    assign capture_cause_flag_o = st_reg.cap_flag;
    assign irq_o                = st_reg.irq;
    assign timer_out_pin_o      = st_reg.out;
    assign timer_out_comp_o     = st_reg.comp;
    assign timer_out_comp_oe_o  = st_reg.comp_oe;
    assign timer_out_pin_oe_o   = st_reg.pin_oe;
endmodule

/* File: tcp_timer_properties.sv */
`timescale 1ns/10ps
// Port-level checks on the timer, bound beside the design
module tcp_timer_chk
    import tcp_pkg::*;
(
    input wire logic        clk_i,                // System clock
    input wire logic        reset_n_i,            // Async reset, low
    input wire tcp_cfg_s    cfg_i,                // Control fields
    input wire logic        count_wr_i,           // Count load
    input wire logic [15:0] count_wdata_i,        // Count data
    input wire logic [15:0] reload_i,             // Reload value
    input wire logic        pwm_wr_i,             // PWM load
    input wire logic [15:0] pwm_wdata_i,          // PWM data
    input wire logic        pin_alt_en_i,         // Alt function on
    input wire logic        timer_in_i,           // Input pin
    input wire logic [15:0] count_o,              // Running count
    input wire logic [15:0] pwm_o,                // PWM register
    input wire logic        capture_cause_flag_o, // Capture flag
    input wire logic        irq_o,                // Interrupt pulse
    input wire logic        timer_out_pin_o,      // Output level
    input wire logic        timer_out_pin_oe_o,   // Output enable
    input wire logic        timer_out_comp_o,     // Complement
    input wire logic        timer_out_comp_oe_o   // Complement enable
);
    // Full-rate running, no count load pending
    wire logic run0 = cfg_i.enable && !count_wr_i
                      && cfg_i.clock_divide_power == 3'h0;
    wire logic cr_run = run0 && cfg_i.mode == TCP_CAP_RESTART;
    // Divide-by-two compare counting
    wire logic div2 = cfg_i.enable && !count_wr_i
                      && cfg_i.clock_divide_power == 3'h1
                      && cfg_i.mode == TCP_COMPARE;
    // Disabled in PWM dual or comparator counter mode; pin follows polarity
    wire logic dis_o = !cfg_i.enable && (cfg_i.mode == TCP_PWM_DUAL
                       || cfg_i.mode == TCP_CMP_COUNTER);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_restart_one;
        cr_run && count_o == reload_i |=> count_o == TCP_COUNT_START;
    endproperty
    a_restart_one: assert property (p_restart_one)
        else $error("count did not restart at one");

    // Pin quiet long enough that no capture competes
    property p_reload_irq;
        ($stable(timer_in_i) [*6]) ##0 (cr_run && count_o == reload_i
        && cfg_i.irq_source_select == TCP_IRQ_RELOAD)
        |=> irq_o && !capture_cause_flag_o;
    endproperty
    a_reload_irq: assert property (p_reload_irq)
        else $error("reload interrupt missing or flagged");

    property p_cap_irq_flag;
        irq_o && $past(cfg_i.mode) == TCP_CAP_RESTART
        && $past(cfg_i.irq_source_select) == TCP_IRQ_CAPTURE
        |-> capture_cause_flag_o;
    endproperty
    a_cap_irq_flag: assert property (p_cap_irq_flag)
        else $error("capture-only interrupt without flag");

    property p_reload_keeps_pwm;
        irq_o && !capture_cause_flag_o && !$past(pwm_wr_i)
        && $past(cfg_i.mode) == TCP_CAP_RESTART |-> $stable(pwm_o);
    endproperty
    a_reload_keeps_pwm: assert property (p_reload_keeps_pwm)
        else $error("reload changed the PWM register");

    property p_cmp_irq;
        run0 && cfg_i.mode == TCP_COMPARE && count_o == reload_i
        && cfg_i.irq_source_select == TCP_IRQ_BOTH
        |=> irq_o && count_o == $past(count_o) + 16'h0001;
    endproperty
    a_cmp_irq: assert property (p_cmp_irq)
        else $error("compare match without irq or count step");

    property p_dis_out;
        $past(reset_n_i) && $past(dis_o)
        |-> timer_out_pin_o == $past(cfg_i.output_polarity_bit);
    endproperty
    a_dis_out: assert property (p_dis_out)
        else $error("disabled output differs from polarity");

    property p_dis_comp;
        $past(reset_n_i) && $past(dis_o)
        && $past(cfg_i.mode) == TCP_PWM_DUAL
        |-> timer_out_comp_o != $past(cfg_i.output_polarity_bit);
    endproperty
    a_dis_comp: assert property (p_dis_comp)
        else $error("disabled complement not inverse of polarity");

    property p_pin_oe;
        $past(reset_n_i) |-> timer_out_pin_oe_o == $past(pin_alt_en_i);
    endproperty
    a_pin_oe: assert property (p_pin_oe)
        else $error("output enable does not follow alt function");

    property p_comp_oe;
        timer_out_comp_oe_o |-> $past(cfg_i.mode) == TCP_PWM_DUAL;
    endproperty
    a_comp_oe: assert property (p_comp_oe)
        else $error("complement driven outside dual mode");

    // Far from reload, a polarity write must not move the pin
    property p_pol_hold;
        cfg_i.enable && $past(cfg_i.enable)
        && cfg_i.mode == TCP_CMP_COUNTER
        && $changed(cfg_i.output_polarity_bit)
        && count_o < reload_i - 16'h0002 |=> $stable(timer_out_pin_o);
    endproperty
    a_pol_hold: assert property (p_pol_hold)
        else $error("polarity write changed running output");

    property p_presc;
        div2 && $past(div2) && $changed(count_o) |=> $stable(count_o);
    endproperty
    a_presc: assert property (p_presc)
        else $error("count stepped twice at divide by two");
endmodule

/* File: tcp_pin_src.sv */
`timescale 1ns/10ps
// Signal source on the timer input pin
module tcp_pin_src (
    input  wire logic level_i, // Requested level
    output wire logic pin_o    // Pin level
);
    // Skew keeps edges well away from the sampling edge
    assign #1.3 pin_o = level_i;
endmodule

/* File: tcp_tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED at %0t: got %0h want %0h", $time, a, b); end end
module tb
    import tcp_pkg::*;
;
    logic        clk_i = 1'b0, reset_n_i = 1'b0;        // Clock, reset
    tcp_cfg_s    cfg_i = '0;                            // Control fields
    logic        count_wr_i = 1'b0, pwm_wr_i = 1'b0;    // Load strobes
    logic [15:0] count_wdata_i = '0, pwm_wdata_i = '0;  // Load data
    logic [15:0] reload_i = 16'h0000;                   // Reload value
    logic        pin_alt_en_i = 1'b0, level = 1'b0;     // Pin controls
    logic        timer_in_i, capture_cause_flag_o, irq_o; // Pin, flags
    logic [15:0] count_o, pwm_o;                        // Count, PWM
    logic        timer_out_pin_o, timer_out_pin_oe_o;   // Output pin
    logic        timer_out_comp_o, timer_out_comp_oe_o; // Complement
    int          bad_count = 0, n_checks = 0;           // Tallies

    initial forever #2 clk_i = ~clk_i;
    tcp_pin_src u_src (.level_i(level), .pin_o(timer_in_i));
    tcp_timer u_dut (.clk_i, .reset_n_i, .cfg_i, .count_wr_i,
        .count_wdata_i, .reload_i, .pwm_wr_i, .pwm_wdata_i, .pin_alt_en_i,
        .timer_in_i, .count_o, .pwm_o, .capture_cause_flag_o, .irq_o,
        .timer_out_pin_o, .timer_out_pin_oe_o, .timer_out_comp_o,
        .timer_out_comp_oe_o);

    // Inputs move one ns after the edge
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    // disable, configure, count, reload, PWM, enable
    task automatic setup(input tcp_mode_e m, input logic p,
        input logic [2:0] pw, dt, input logic [1:0] s,
        input logic [15:0] c, r, w);
        cfg_i.enable = 1'b0;
        cyc(1);
        cfg_i = '{1'b0, m, p, pw, dt, s};
        cyc(1);
        count_wr_i = 1'b1;
        count_wdata_i = c;
        cyc(1);
        count_wr_i = 1'b0;
        reload_i = r;
        pwm_wr_i = 1'b1;
        pwm_wdata_i = w;
        cyc(1);
        pwm_wr_i = 1'b0;
        cfg_i.enable = 1'b1;
        cyc(1);
    endtask
    // Watched output by code: irq, pin, complement
    function automatic logic pick(input int s);
        case (s)
            0: return irq_o;
            1: return timer_out_pin_o;
            default: return timer_out_comp_o;
        endcase
    endfunction
    // Bounded wait for a level, cycles counted in n
    task automatic wait_for(input int s, input logic v, input int mx,
        output int n);
        for (n = 0; pick(s) !== v && n < mx; n++) cyc(1);
    endtask

    task automatic t_capture(input logic p, input logic [1:0] s);
        int n;
        logic [15:0] keep;
        level = p;
        setup(TCP_CAP_RESTART, p, 3'h0, 3'h0, s, 16'h0001, 16'h0040, '0);
        cyc(6);
        level = !p;
        wait_for(0, 1'b1, 8, n);
        if (s != TCP_IRQ_RELOAD) begin
            `CHK({irq_o, capture_cause_flag_o, count_o}, 18'h30001)
            `CHK(pwm_o != 16'h0000, 1'b1)
        end else
            `CHK(irq_o, 1'b0)
        level = p;
        keep = pwm_o;
        cyc(1);
        wait_for(0, 1'b1, 8, n);
        `CHK(irq_o, 1'b0)
        wait_for(0, 1'b1, 80, n);
        if (s != TCP_IRQ_CAPTURE) begin
            `CHK({irq_o, capture_cause_flag_o, pwm_o}, {2'b10, keep})
            cyc(1);
            wait_for(0, 1'b1, 80, n);
            `CHK(n, 63)
        end else
            `CHK(irq_o, 1'b0)
    endtask

    task automatic t_capcmp(input logic p);
        int n;
        level = p;
        setup(TCP_CAP_CMP, p, 3'h0, 3'h0, 2'h0, 16'h0001, 16'h0100, '0);
        cyc(8);
        `CHK(count_o, 16'h0001)
        level = !p;
        cyc(8);
        `CHK(count_o > 16'h0002, 1'b1)
        level = p;
        cyc(4);
        level = !p;
        wait_for(0, 1'b1, 8, n);
        `CHK({irq_o, pwm_o > 16'h0004}, 2'b11)
    endtask

    task automatic t_pwm(input logic p);
        int n;
        setup(TCP_PWM_DUAL, p, 3'h0, 3'h3, 2'h0, 16'h1, 16'h40, 16'h20);
        wait_for(2, p, 100, n);
        wait_for(1, !p, 20, n);
        `CHK(n inside {[3:4]}, 1'b1)
        wait_for(1, p, 100, n);
        `CHK(timer_out_comp_o, p)
        wait_for(2, !p, 20, n);
        `CHK(n inside {[3:4]}, 1'b1)
        cfg_i.enable = 1'b0;
        cyc(2);
        `CHK({timer_out_pin_o, timer_out_comp_o}, {p, !p})
        `CHK(timer_out_comp_oe_o, 1'b1)
    endtask

    task automatic t_compare();
        logic [15:0] st [2] = '{16'h0001, 16'hFFFE};
        logic [15:0] rl [2] = '{16'h0008, 16'hFFFF};
        int n;
        for (int i = 0; i < 2; i++) begin
            setup(TCP_COMPARE, 1'b0, 3'h0, 3'h0, 2'h0, st[i], rl[i], '0);
            wait_for(0, 1'b1, 20, n);
            `CHK({irq_o, count_o}, {1'b1, rl[i] + 16'h0001})
            `CHK(timer_out_comp_oe_o, 1'b0)
            cyc(1);
            `CHK({irq_o, count_o}, {1'b0, rl[i] + 16'h0002})
        end
    endtask

    task automatic t_presc();
        logic [15:0] c;
        int n;
        for (int p = 0; p < 4; p++) begin
            setup(TCP_COMPARE, 1'b0, p[2:0], 3'h0, 2'h0, 16'h1, 16'hFFF0, '0);
            c = count_o;
            for (n = 0; count_o === c && n < 20; n++) cyc(1);
            c = count_o;
            for (n = 0; count_o === c && n < 20; n++) cyc(1);
            `CHK(n, 1 << p)
        end
    endtask

    task automatic t_cmpcnt();
        int n;
        cfg_i = '{1'b0, TCP_CMP_COUNTER, 1'b1, 3'h0, 3'h0, 2'h0};
        pin_alt_en_i = 1'b1;
        cyc(2);
        `CHK({timer_out_pin_o, timer_out_pin_oe_o}, 2'b11)
        setup(TCP_CMP_COUNTER, 1'b1, 3'h0, 3'h0, 2'h0, 16'h1, 16'h8, '0);
        cfg_i.output_polarity_bit = 1'b0;
        cyc(1);
        `CHK(timer_out_pin_o, 1'b1)
        wait_for(1, 1'b0, 20, n);
        cyc(1);
        wait_for(1, 1'b1, 20, n);
        `CHK(n, 7)
    endtask

    // Single exit for the whole run
    task automatic tally_and_finish();
        $display("bad_count=%0d n_checks=%0d", bad_count, n_checks);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        cyc(2);
        `CHK({count_o, pwm_o, capture_cause_flag_o, irq_o, timer_out_pin_o,
              timer_out_comp_o, timer_out_pin_oe_o, timer_out_comp_oe_o},
             38'h04)
        cyc(3);
        reset_n_i = 1'b1;
        cyc(1);
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) t_capture(p[0], s[1:0]);
            t_capcmp(p[0]);
            t_pwm(p[0]);
        end
        t_compare();
        t_presc();
        t_cmpcnt();
        tally_and_finish();
    end
    // Watchdog: several times the expected run length
    initial begin
        #60000;
        bad_count++;
        tally_and_finish();
    end
endmodule

bind tcp_timer tcp_timer_chk u_chk (.clk_i, .reset_n_i, .cfg_i,
    .count_wr_i, .count_wdata_i, .reload_i, .pwm_wr_i, .pwm_wdata_i,
    .pin_alt_en_i, .timer_in_i, .count_o, .pwm_o, .capture_cause_flag_o,
    .irq_o, .timer_out_pin_o, .timer_out_pin_oe_o, .timer_out_comp_o,
    .timer_out_comp_oe_o);
